//--- testbench/odt_ctrl_asserts.sv
// concurrent checks on the termination control ports
`timescale 1ns/1ps
module odt_ctrl_asserts (
   // clocks and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic link_clk,
   // inputs
   input wire logic ale,
   input wire logic cle,
   input wire logic ce_n,
   input wire logic odt_enable,
   input wire logic ddr2_selected,
   input wire logic matrix_configure,
   input wire logic lun_executing,
   // outputs
   input wire odt_pkg::odt_drive_t odt_drive,
   input wire logic matrix_mode
);
   wire logic term_on = odt_drive.dq_on || odt_drive.re_on;
   sequence ctrl_rise; $rose(ale) || $rose(cle) || $rose(ce_n); endsequence
   sequence iface_off; (!ddr2_selected)[*8]; endsequence
   sequence odt_off; (!odt_enable)[*8]; endsequence
   sequence self_idle; (!matrix_mode && !lun_executing)[*8]; endsequence
   rise_off_a:
      assert property (@(posedge link_clk) disable iff (sys_rst) ctrl_rise |=> !term_on) else $error("on after rise");
   cmd_off_a:
      assert property (@(posedge link_clk) disable iff (sys_rst) ale || cle || ce_n |=> !term_on) else $error("on in cmd");
   iface_gate_a:
      assert property (@(posedge link_clk) disable iff (sys_rst) iface_off |-> !term_on) else $error("on off iface");
   enable_gate_a:
      assert property (@(posedge link_clk) disable iff (sys_rst) odt_off |-> !term_on) else $error("on while off");
   self_exec_a:
      assert property (@(posedge link_clk) disable iff (sys_rst) self_idle |-> !term_on) else $error("idle lun on");
   strength_ok_a:
      assert property (@(posedge link_clk) disable iff (sys_rst) odt_drive.dq_on |-> odt_drive.dq_strength inside
         {[4'h1:4'h5]}) else $error("bad strength");
   mode_set_a:
      assert property (@(posedge sys_clk) disable iff (sys_rst) matrix_configure |-> ##[1:2] matrix_mode)
         else $error("mode not set");
   mode_sticky_a:
      assert property (@(posedge sys_clk) disable iff (sys_rst) matrix_mode |=> matrix_mode) else $error("mode lost");
endmodule
bind odt_ctrl odt_ctrl_asserts chk (
   .sys_clk(sys_clk),
   .sys_rst(sys_rst),
   .link_clk(link_clk),
   .ale(ale),
   .cle(cle),
   .ce_n(ce_n),
   .odt_enable(odt_enable),
   .ddr2_selected(ddr2_selected),
   .matrix_configure(matrix_configure),
   .lun_executing(lun_executing),
   .odt_drive(odt_drive),
   .matrix_mode(matrix_mode)
);

//--- testbench/odt_host_model.sv
// host pin model that frames command and data cycles
`timescale 1ns/1ps
module odt_host_model (
   // cycle kind: 0 idle, 1 command/address, 2 data in, 3 data out
   input wire logic link_clk,
   input wire logic [1:0] phase,
   // flash pins
   output logic ale,
   output logic cle,
   output logic ce_n,
   output logic dqs_toggle,
   output logic re_n
);
   initial {ale, cle, ce_n, dqs_toggle, re_n} = 5'h05;
   always @(posedge link_clk) begin
      ce_n <= phase == 2'h0;
      cle <= phase == 2'h1 && !cle;
      ale <= phase == 2'h1 && cle;
      dqs_toggle <= phase == 2'h2 && !dqs_toggle;
      re_n <= phase != 2'h3 || !re_n;
   end
endmodule

//--- testbench/tb.sv
// self-checking bench for the termination control block
`timescale 1ns/1ps
module tb;
   logic sys_clk = 1'h0;
   logic link_clk = 1'h0;
   logic sys_rst = 1'h1, matrix_configure = 1'h0, burst_is_output = 1'h0, configured_terminator = 1'h1;
   logic odt_enable = 1'h1, ddr2_selected = 1'h1, lun_executing = 1'h1, burst_active = 1'h1;
   logic [3:0] lun_volume = 4'h0, selected_volume = 4'h0;
   logic [1:0] phase = 2'h0;
   odt_pkg::odt_matrix_t matrix_in = 32'h0;
   logic ale, cle, ce_n, dqs_toggle, re_n, matrix_mode;
   odt_pkg::odt_drive_t odt_drive;
   odt_pkg::odt_lun_state_t lun_state;
   int n_errors = 0;
   int cmp_count = 0;
   wire logic [9:0] drv = {odt_drive.dq_on, odt_drive.re_on, odt_drive.dq_strength & {4{odt_drive.dq_on}},
      odt_drive.re_strength & {4{odt_drive.re_on}}};
   always #20 sys_clk = ~sys_clk;
   always #62.5 link_clk = ~link_clk;
   odt_ctrl uut (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .link_clk(link_clk),
      .ale(ale),
      .cle(cle),
      .ce_n(ce_n),
      .dqs_toggle(dqs_toggle),
      .re_n(re_n),
      .odt_enable(odt_enable),
      .ddr2_selected(ddr2_selected),
      .matrix_configure(matrix_configure),
      .matrix_in(matrix_in),
      .lun_volume(lun_volume),
      .selected_volume(selected_volume),
      .lun_executing(lun_executing),
      .burst_active(burst_active),
      .burst_is_output(burst_is_output),
      .configured_terminator(configured_terminator),
      .odt_drive(odt_drive),
      .matrix_mode(matrix_mode),
      .lun_state(lun_state)
   );
   odt_host_model host (
      .link_clk(link_clk),
      .phase(phase),
      .ale(ale),
      .cle(cle),
      .ce_n(ce_n),
      .dqs_toggle(dqs_toggle),
      .re_n(re_n)
   );
   task automatic print_verdict();
      $display("checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // waits a bounded time for the expected view, sel 1 views mode and lun state
   task automatic check(input string what, input bit sel, input logic [9:0] exp);
      logic [9:0] got;
      for (int n = 0; n < 40; n++) begin
         @(negedge sys_clk);
         got = sel ? {7'h00, matrix_mode, lun_state} : drv;
         if (got === exp) break;
      end
      cmp_count++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         n_errors++;
         print_verdict();
      end
   endtask
   initial begin
      repeat (20) @(negedge sys_clk);
      sys_rst = 1'h0;
      phase = 2'h2;
      check("self in", 0, {2'h2, odt_pkg::RTT_50, 4'h0});
      burst_is_output = 1'h1;
      phase = 2'h3;
      check("self out", 0, {2'h3, odt_pkg::RTT_50, odt_pkg::RTT_50});
      phase = 2'h1;
      check("cmd", 0, 10'h000);
      phase = 2'h3;
      check("resume", 0, {2'h3, odt_pkg::RTT_50, odt_pkg::RTT_50});
      ddr2_selected = 1'h0;
      check("iface", 0, 10'h000);
      repeat (30) @(negedge sys_clk);
      check("iface hold", 0, 10'h000);
      ddr2_selected = 1'h1;
      check("resume", 0, {2'h3, odt_pkg::RTT_50, odt_pkg::RTT_50});
      odt_enable = 1'h0;
      check("disabled", 0, 10'h000);
      repeat (30) @(negedge sys_clk);
      check("disabled hold", 0, 10'h000);
      odt_enable = 1'h1;
      check("resume", 0, {2'h3, odt_pkg::RTT_50, odt_pkg::RTT_50});
      lun_executing = 1'h0;
      check("idle lun", 0, 10'h000);
      repeat (30) @(negedge sys_clk);
      check("idle hold", 0, 10'h000);
      lun_executing = 1'h1;
      burst_is_output = 1'h0;
      phase = 2'h2;
      selected_volume = 4'h2;
      matrix_in = {8'h0C, 8'h00, 8'h42, 8'h01};
      matrix_configure = 1'h1;
      @(negedge sys_clk);
      matrix_configure = 1'h0;
      check("mode", 1, {8'h01, odt_pkg::ODT_SNIFF});
      check("sniff in", 0, {2'h2, odt_pkg::RTT_100, 4'h0});
      burst_is_output = 1'h1;
      phase = 2'h3;
      check("sniff out", 0, {2'h3, odt_pkg::RTT_50, odt_pkg::RTT_150});
      for (int v = 0; v < 4; v++) begin
         selected_volume = 4'(v);
         check("state", 1, {8'h01, v == 0 ? odt_pkg::ODT_SELECTED : matrix_in.volume_mask_low[v] ?
            odt_pkg::ODT_SNIFF : odt_pkg::ODT_DESELECTED});
      end
      selected_volume = 4'h1;
      check("deselected", 0, 10'h000);
      selected_volume = 4'h0;
      check("sel exec", 0, {2'h3, odt_pkg::RTT_50, odt_pkg::RTT_150});
      lun_executing = 1'h0;
      check("sel idle", 0, 10'h000);
      lun_executing = 1'h1;
      burst_active = 1'h0;
      check("no burst", 0, 10'h000);
      print_verdict();
   end
endmodule

//--- verilog/odt_ctrl.sv
// on-die termination control for one lun of a ddr source-synchronous nand
// Summary of operation
// - terminate only under ddr source-synchronous interface
// - terminate only during data cycles
// - ale, cle or ce rising disables termination
// - default self-termination when no matrix programmed
// - self mode: only executing lun terminates
// - matrix configure switches target to matrix
// - per-lun strengths for re, output, input
// - matrix states selected, sniff, deselected
// - terminator may serve own or other volume
// - selected volume: executing or configured luns terminate
// - selected luns track burst and cycle type
// - sniff luns watch ale, cle, dqs, re
// - support 50, 75, 100, 150, optional 30
// - volume mask low and high bytes, one bit per volume
// - decode example strength codes
`timescale 1ns/1ps
module odt_ctrl #(
   parameter int VOL_BITS = 4,
   parameter bit SUPPORT_30 = 1'b1
) (
   // system
   input wire logic sys_clk,
   input wire logic sys_rst,
   // link pins, sampled on the link clock
   input wire logic link_clk,
   input wire logic ale,
   input wire logic cle,
   input wire logic ce_n,
   input wire logic dqs_toggle,
   input wire logic re_n,
   // core configuration and command status (sys_clk domain)
   input wire logic odt_enable,
   input wire logic ddr2_selected,
   input wire logic matrix_configure,
   input wire odt_pkg::odt_matrix_t matrix_in,
   input wire logic [VOL_BITS-1:0] lun_volume,
   input wire logic [VOL_BITS-1:0] selected_volume,
   input wire logic lun_executing,
   input wire logic burst_active,
   input wire logic burst_is_output,
   input wire logic configured_terminator,
   // termination outputs (link domain), matrix mode and lun state (sys_clk domain)
   output odt_pkg::odt_drive_t odt_drive,
   output logic matrix_mode,
   output odt_pkg::odt_lun_state_t lun_state
);
   // ---------------- core domain ----------------
   typedef struct packed {
      logic matrix_mode;
      odt_pkg::odt_matrix_t matrix;
      odt_pkg::odt_lun_state_t lun_state;
      logic want_on;
      logic want_out;
      logic cfg_toggle;
   } odt_core_t;

   odt_core_t core;
   odt_core_t next_core;
   logic [15:0] vol_mask;
   logic terminator_for_sel;
   logic on_sel_volume;
   logic want_self;
   logic want_selected;

   assign vol_mask = {core.matrix.volume_mask_high, core.matrix.volume_mask_low};
   assign terminator_for_sel = vol_mask[selected_volume];
   // lun sits on the addressed volume
   assign on_sel_volume = lun_volume == selected_volume;

   assign want_self = lun_executing && burst_active;
   assign want_selected = burst_active && (lun_executing || (configured_terminator && terminator_for_sel));

   always_comb begin
      next_core = core;

      if (matrix_configure) begin
         next_core.matrix_mode = 1'b1;
         next_core.matrix = matrix_in;
         // tells the link side that a fresh matrix is waiting
         next_core.cfg_toggle = !core.cfg_toggle;
      end

      // classify lun for the addressed volume
      if (on_sel_volume) begin
         next_core.lun_state = odt_pkg::ODT_SELECTED;
      end else if (terminator_for_sel) begin
         next_core.lun_state = odt_pkg::ODT_SNIFF;
      end else begin
         next_core.lun_state = odt_pkg::ODT_DESELECTED;
      end

      // only with ddr interface and enable
      if (!(odt_enable && ddr2_selected)) begin
         next_core.want_on = 1'b0;
      end else if (!core.matrix_mode) begin
         next_core.want_on = want_self;
      end else begin
         case (next_core.lun_state)
            odt_pkg::ODT_SELECTED: begin
               next_core.want_on = want_selected;
            end
            // sniff relies on pin activity at the link
            odt_pkg::ODT_SNIFF: begin
               next_core.want_on = 1'b1;
            end
            default: begin
               next_core.want_on = 1'b0;
            end
         endcase
      end
      next_core.want_out = burst_is_output;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         core.matrix_mode <= 1'b0;
         core.matrix.volume_mask_low <= odt_pkg::MASK_RST;
         core.matrix.volume_mask_high <= odt_pkg::MASK_RST;
         core.matrix.data_strength_byte <= odt_pkg::STRENGTH_RST;
         core.matrix.read_strobe_strength_byte <= odt_pkg::STRENGTH_RST;
         core.lun_state <= odt_pkg::ODT_DESELECTED;
         core.want_on <= 1'b0;
         core.want_out <= 1'b0;
         core.cfg_toggle <= 1'b0;
      end else begin
         core <= next_core;
      end
   end

   assign matrix_mode = core.matrix_mode;
   assign lun_state = core.lun_state;

   // ---------------- link domain ----------------
   // the matrix crosses by a toggle: it is copied only after the toggle has settled,
   // so two configure pulses closer than one link clock may leave the older codes
   logic link_rst_m;
   logic link_rst;
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         link_rst_m <= 1'b1;
         link_rst <= 1'b1;
      end else begin
         link_rst_m <= 1'b0;
         link_rst <= link_rst_m;
      end
   end

   typedef struct packed {
      logic [1:0] on_s;
      logic [1:0] out_s;
      logic [1:0] sniff_s;
      logic [2:0] self_s;
      logic [2:0] cfg_s;
      logic prev_ale;
      logic prev_cle;
      logic prev_ce;
      logic armed;
      logic [3:0] out_code;
      logic [3:0] in_code;
      logic [3:0] re_code;
      odt_pkg::odt_drive_t drive;
   } odt_link_t;

   odt_link_t lnk;
   odt_link_t next_lnk;
   logic ctrl_rise;
   logic data_cycle;
   logic strobe_seen;
   logic cfg_load;
   logic term_on;
   logic [3:0] out_nib;
   logic [3:0] in_nib;
   logic [3:0] re_nib;

   // rising edge on ale, cle or ce
   assign ctrl_rise = (ale && !lnk.prev_ale) || (cle && !lnk.prev_cle) || (ce_n && !lnk.prev_ce);
   // data cycle: chip enabled, not command or address
   assign data_cycle = !ce_n && !ale && !cle;
   // strobe or read-enable activity on the pins
   assign strobe_seen = dqs_toggle || !re_n;
   // new matrix: held still for two link edges before it is copied
   assign cfg_load = lnk.cfg_s[2] ^ lnk.cfg_s[1];

   function automatic logic [3:0] odt_legal(input logic [3:0] code);
      logic [3:0] r;
      r = odt_pkg::RTT_OFF;
      case (code)
         odt_pkg::RTT_150: r = code;
         odt_pkg::RTT_100: r = code;
         odt_pkg::RTT_75: r = code;
         odt_pkg::RTT_50: r = code;
         odt_pkg::RTT_30: r = SUPPORT_30 ? code : odt_pkg::RTT_OFF;
         default: r = odt_pkg::RTT_OFF;
      endcase
      return r;
   endfunction

   assign out_nib = odt_legal(core.matrix.data_strength_byte[odt_pkg::DATA_OUT_LSB +: 4]);
   assign in_nib = odt_legal(core.matrix.data_strength_byte[odt_pkg::DATA_IN_LSB +: 4]);
   assign re_nib = odt_legal(core.matrix.read_strobe_strength_byte[odt_pkg::RE_LSB +: 4]);

   always_comb begin
      next_lnk = lnk;
      term_on = 1'b0;

      // level synchronisers from the core clock
      next_lnk.on_s = {lnk.on_s[0], core.want_on};
      next_lnk.out_s = {lnk.out_s[0], core.want_out};
      next_lnk.sniff_s = {lnk.sniff_s[0], core.lun_state == odt_pkg::ODT_SNIFF};
      // three stages, as many as the code copy takes, so matrix mode never meets stale codes
      next_lnk.self_s = {lnk.self_s[1:0], !core.matrix_mode};
      next_lnk.cfg_s = {lnk.cfg_s[1:0], core.cfg_toggle};

      // pin history for the edge detector
      next_lnk.prev_ale = ale;
      next_lnk.prev_cle = cle;
      next_lnk.prev_ce = ce_n;

      // codes are copied once per configure, never read while they may move
      if (cfg_load) begin
         next_lnk.out_code = out_nib;
         next_lnk.in_code = in_nib;
         next_lnk.re_code = re_nib;
      end

      // sniff arms on strobe or read-enable activity
      // burst ends on ale, cle or ce rise
      if (ctrl_rise || !data_cycle) begin
         next_lnk.armed = 1'b0;
      end else if (strobe_seen) begin
         next_lnk.armed = 1'b1;
      end

      term_on = lnk.on_s[1] && data_cycle && !ctrl_rise && (!lnk.sniff_s[1] || lnk.armed);
      next_lnk.drive.dq_on = term_on;
      next_lnk.drive.re_on = term_on && lnk.out_s[1];

      // matrix mode: direction picks output or input strength; self mode: RTT_50 on both
      if (lnk.self_s[2]) begin
         next_lnk.drive.dq_strength = odt_pkg::RTT_50;
         next_lnk.drive.re_strength = odt_pkg::RTT_50;
      end else begin
         next_lnk.drive.dq_strength = lnk.out_s[1] ? lnk.out_code : lnk.in_code;
         next_lnk.drive.re_strength = lnk.re_code;
      end
      if (!term_on) begin
         next_lnk.drive.dq_strength = odt_pkg::RTT_OFF;
         next_lnk.drive.re_strength = odt_pkg::RTT_OFF;
      end
      if (next_lnk.drive.dq_strength == odt_pkg::RTT_OFF) begin
         next_lnk.drive.dq_on = 1'b0;
      end
      if (next_lnk.drive.re_strength == odt_pkg::RTT_OFF) begin
         next_lnk.drive.re_on = 1'b0;
      end
   end

   always_ff @(posedge link_clk or posedge link_rst) begin
      if (link_rst) begin
         lnk.on_s <= 2'b00;
         lnk.out_s <= 2'b00;
         lnk.sniff_s <= 2'b00;
         lnk.self_s <= 3'b111;
         lnk.cfg_s <= 3'b000;
         lnk.prev_ale <= 1'b0;
         lnk.prev_cle <= 1'b0;
         // ce_n idles high, so no false edge follows reset
         lnk.prev_ce <= 1'b1;
         lnk.armed <= 1'b0;
         lnk.out_code <= odt_pkg::RTT_OFF;
         lnk.in_code <= odt_pkg::RTT_OFF;
         lnk.re_code <= odt_pkg::RTT_OFF;
         lnk.drive.dq_on <= 1'b0;
         lnk.drive.re_on <= 1'b0;
         lnk.drive.dq_strength <= odt_pkg::RTT_OFF;
         lnk.drive.re_strength <= odt_pkg::RTT_OFF;
      end else begin
         lnk <= next_lnk;
      end
   end

   assign odt_drive = lnk.drive;
endmodule

//--- verilog/odt_pkg.sv
// shared constants and carrier types for the on-die termination control block
package odt_pkg;
   // termination strength codes (4-bit nibbles of the strength bytes)
   localparam logic [3:0] RTT_OFF = 4'h0;
   localparam logic [3:0] RTT_150 = 4'h1;
   localparam logic [3:0] RTT_100 = 4'h2;
   localparam logic [3:0] RTT_75 = 4'h3;
   localparam logic [3:0] RTT_50 = 4'h4;
   localparam logic [3:0] RTT_30 = 4'h5;
   // nibble positions inside the data and read strobe strength bytes
   localparam int DATA_IN_LSB = 0;
   localparam int DATA_OUT_LSB = 4;
   localparam int RE_LSB = 0;
   // reset values
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] STRENGTH_RST = 8'h00;
   // synchroniser depth
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      ODT_DESELECTED = 2'b00,
      ODT_SELECTED = 2'b01,
      ODT_SNIFF = 2'b10
   } odt_lun_state_t;

   // matrix configuration for one lun
   typedef struct packed {
      logic [7:0] volume_mask_low;
      logic [7:0] volume_mask_high;
      logic [7:0] data_strength_byte;
      logic [7:0] read_strobe_strength_byte;
   } odt_matrix_t;

   // termination applied at the pins
   typedef struct packed {
      logic dq_on;
      logic re_on;
      logic [3:0] dq_strength;
      logic [3:0] re_strength;
   } odt_drive_t;
endpackage
